/* File: rtl/airf_pkg.sv */
package airf_pkg;

	// ==========================================
	// Register offsets within a set
	localparam logic [2:0] OFS_TIMER_LOW = 3'h0;
	localparam logic [2:0] OFS_TIMER_HIGH = 3'h1;
	localparam logic [2:0] OFS_MODE_SELECT = 3'h2;
	localparam logic [2:0] OFS_BANK_SELECT = 3'h3;
	localparam logic [2:0] OFS_TX_LEN_LOW = 3'h4;
	localparam logic [2:0] OFS_TX_LEN_HIGH = 3'h5;
	localparam logic [2:0] OFS_RX_LEN_LOW = 3'h6;
	localparam logic [2:0] OFS_RX_LEN_HIGH = 3'h7;
	localparam logic [2:0] OFS_VERSION_ID = 3'h0;
	localparam logic [2:0] OFS_MIRROR_PORT = 3'h1;
	localparam logic [2:0] OFS_MIRROR_FIFO = 3'h2;
	localparam logic [2:0] OFS_TX_FIFO_LEVEL = 3'h6;
	localparam logic [2:0] OFS_RX_FIFO_LEVEL = 3'h7;
	localparam logic [2:0] OFS_IR_CONFIG = 3'h4;

	// ==========================================
	// Bank select codes, also the read-back constants
	localparam logic [7:0] BANK_SET2 = 8'hE0;
	localparam logic [7:0] BANK_SET3 = 8'hE4;
	localparam logic [7:0] BANK_SET4 = 8'hE8;
	localparam logic [7:0] BANK_SET5 = 8'hEC;
	localparam logic [7:0] BANK_RESET = 8'h00;

	// ==========================================
	// Field layouts and masks
	localparam int MODE_TIMER_RUN = 0;
	localparam int MODE_READBACK_TEST = 1;
	localparam int MODE_SEL_LO = 2;
	localparam int CFG_AUTO_PACKET = 5;
	localparam logic [7:0] MODE_WRITE_MASK = 8'h0F;
	localparam logic [7:0] CFG_WRITE_MASK = 8'h73;
	localparam int TIMER_W = 12;
	localparam int FRAME_W = 13;
	localparam int LEVEL_W = 6;
	localparam int PRESCALE_W = 17;
	localparam logic [7:0] VERSION_ID_DEFAULT = 8'h5A; // Arbitrary value

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ==========================================
	// Operating modes
	typedef enum logic [1:0] {
		MODE_LEGACY_IR = 2'h0,
		MODE_CONSUMER_IR = 2'h1,
		MODE_LEGACY_ASK = 2'h2,
		MODE_LEGACY_SIR = 2'h3
	} airf_mode_t;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} airf_bus_req_t;

	typedef struct packed {
		logic [LEVEL_W-1:0] txFifoLevel;
		logic [LEVEL_W-1:0] rxFifoLevel;
		logic [7:0] portControl;
		logic [7:0] fifoControl;
	} airf_core_stat_t;

	typedef struct packed {
		logic txByteSent;
		logic rxByteValid;
		logic rxFrameStart;
	} airf_link_ev_t;

	typedef struct packed {
		logic [7:0] bankSel;
		logic [TIMER_W-1:0] timerReload;
		logic [TIMER_W-1:0] timerCount;
		logic [PRESCALE_W-1:0] prescale;
		logic [7:0] modeSel;
		logic [7:0] irConfig;
		logic [FRAME_W-1:0] txLength;
		logic [FRAME_W-1:0] txRemain;
		logic [FRAME_W-1:0] rxLimit;
		logic [FRAME_W-1:0] rxCount;
		logic timerFlag;
		logic maxLenFlag;
		logic txFrameEnd;
		logic rxStore;
		logic [7:0] rdata;
	} airf_state_t;

endpackage

/* File: rtl/airf_regs.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps

// Contract
// - Transmit FIFO level reads back six bits, upper two zero, read only.
// - Receive FIFO level reads back six bits, upper two zero, read only.
// - Set 3 offset 0 returns a fixed version code; writes ignored.
// - Set 3 offset 1 mirrors the set 0 port control register.
// - Set 3 offset 2 mirrors the set 0 FIFO control register.
// - Offset 3 write selects the set; reads E4 in set 3.
// - In set 4 offset 3 reads E8; writing it selects the set.
// - Twelve-bit timer decrements once per millisecond, loaded from two bytes.
// - Timer counts only while the timer-run bit is one.
// - At zero the timer sets its expired flag and reloads.
// - Mode bits 3:2 pick the infrared mode; bits 7:4 reserved zero.
// - Readback-test bit makes timer reads return the reload value.
// - Transmit frame length is thirteen bits, used only in auto packet mode.
// - Auto packet mode splits the transmit stream into programmed-length frames.
// - Transmit length reads return bytes left in the current frame.
// - Receive frame length is a thirteen-bit limit with a byte up-counter.
// - Overlong frame sets the exceeded flag and blocks storing until frame start.
// - Receive length reads return bytes received so far in the frame.
// - Set 5 configuration bit 5 enables automatic packet mode.
module airf_regs
	import airf_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT,
	parameter logic [7:0] VERSION_ID = VERSION_ID_DEFAULT
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire airf_bus_req_t busReq,
	output logic [7:0] rdata,
	// Core status in
	input wire airf_core_stat_t coreStat,
	// Link events in
	input wire airf_link_ev_t linkEv,
	input wire logic timerFlagClear,
	// Controls and events out
	output logic timerExpired,
	output logic [1:0] irMode,
	output logic autoPacketMode,
	output logic txFrameEnd,
	output logic rxStore,
	output logic maxLengthExceeded
);

	// ==========================================
	// Set decode
	typedef enum logic [4:0] {
		SET_OTHER = 5'h01,
		SET_TWO = 5'h02,
		SET_THREE = 5'h04,
		SET_FOUR = 5'h08,
		SET_FIVE = 5'h10
	} airf_set_t;

	localparam logic [PRESCALE_W-1:0] TICK_LAST = PRESCALE_W'(TICK_CYCLES - 1);
	localparam logic [FRAME_W-1:0] FRAME_ONE = 13'h0001;

	airf_state_t s_q;
	airf_state_t s_d;
	airf_set_t activeSet;
	logic tick;
	logic [TIMER_W-1:0] timerView;

	always_comb
	begin
		case (s_q.bankSel)
			BANK_SET2: activeSet = SET_TWO;
			BANK_SET3: activeSet = SET_THREE;
			BANK_SET4: activeSet = SET_FOUR;
			BANK_SET5: activeSet = SET_FIVE;
			default: activeSet = SET_OTHER;
		endcase
	end

	// ==========================================
	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.txFrameEnd = 1'b0;
		s_d.rxStore = 1'b0;
		s_d.rdata = 8'h00;
		tick = 1'b0;
		timerView = s_q.modeSel[MODE_READBACK_TEST] ? s_q.timerReload : s_q.timerCount;

		if (!s_q.modeSel[MODE_TIMER_RUN])
		begin
			s_d.prescale = '0;
		end
		else if (s_q.prescale == TICK_LAST)
		begin
			s_d.prescale = '0;
			tick = 1'b1;
		end
		else
		begin
			s_d.prescale = s_q.prescale + 1'b1;
		end

		// Clear first so a same-cycle expiry wins
		if (timerFlagClear)
		begin
			s_d.timerFlag = 1'b0;
		end
		if (tick)
		begin
			if (s_q.timerCount == '0)
			begin
				s_d.timerFlag = 1'b1;
				s_d.timerCount = s_q.timerReload;
			end
			else
			begin
				s_d.timerCount = s_q.timerCount - 1'b1;
			end
		end

		if (linkEv.txByteSent && s_q.irConfig[CFG_AUTO_PACKET] && s_q.txLength != '0)
		begin
			if (s_q.txRemain <= FRAME_ONE)
			begin
				s_d.txFrameEnd = 1'b1;
				s_d.txRemain = s_q.txLength;
			end
			else
			begin
				s_d.txRemain = s_q.txRemain - 1'b1;
			end
		end

		// New frame reopens the receive path
		if (linkEv.rxFrameStart)
		begin
			s_d.rxCount = '0;
			s_d.maxLenFlag = 1'b0;
		end
		if (linkEv.rxByteValid)
		begin
			if (linkEv.rxFrameStart)
			begin
				s_d.rxCount = FRAME_ONE;
				s_d.rxStore = 1'b1;
			end
			else if (s_q.maxLenFlag || s_q.rxCount >= s_q.rxLimit)
			begin
				s_d.maxLenFlag = 1'b1;
			end
			else
			begin
				s_d.rxCount = s_q.rxCount + 1'b1;
				s_d.rxStore = 1'b1;
			end
		end

		// ==========================================
		// Register writes
		if (busReq.wr)
		begin
			if (busReq.addr == OFS_BANK_SELECT)
			begin
				// Any set selects via offset 3
				s_d.bankSel = busReq.wdata;
			end
			else if (activeSet == SET_FOUR)
			begin
				case (busReq.addr)
					OFS_TIMER_LOW:
					begin
						s_d.timerReload = {s_q.timerReload[TIMER_W-1:8], busReq.wdata};
						s_d.timerCount = {s_q.timerReload[TIMER_W-1:8], busReq.wdata};
					end
					OFS_TIMER_HIGH:
					begin
						s_d.timerReload = {busReq.wdata[TIMER_W-9:0], s_q.timerReload[7:0]};
						s_d.timerCount = {busReq.wdata[TIMER_W-9:0], s_q.timerReload[7:0]};
					end
					OFS_MODE_SELECT:
					begin
						s_d.modeSel = busReq.wdata & MODE_WRITE_MASK;
					end
					OFS_TX_LEN_LOW:
					begin
						s_d.txLength = {s_q.txLength[FRAME_W-1:8], busReq.wdata};
						s_d.txRemain = {s_q.txLength[FRAME_W-1:8], busReq.wdata};
					end
					OFS_TX_LEN_HIGH:
					begin
						s_d.txLength = {busReq.wdata[FRAME_W-9:0], s_q.txLength[7:0]};
						s_d.txRemain = {busReq.wdata[FRAME_W-9:0], s_q.txLength[7:0]};
					end
					OFS_RX_LEN_LOW:
					begin
						s_d.rxLimit = {s_q.rxLimit[FRAME_W-1:8], busReq.wdata};
					end
					OFS_RX_LEN_HIGH:
					begin
						s_d.rxLimit = {busReq.wdata[FRAME_W-9:0], s_q.rxLimit[7:0]};
					end
					default:
					begin
					end
				endcase
			end
			else if (activeSet == SET_FIVE && busReq.addr == OFS_IR_CONFIG)
			begin
				s_d.irConfig = busReq.wdata & CFG_WRITE_MASK;
			end
		end

		// ==========================================
		// Register reads, data in the next cycle
		if (busReq.rd)
		begin
			case (activeSet)
				SET_TWO:
				begin
					case (busReq.addr)
						OFS_TX_FIFO_LEVEL: s_d.rdata = {2'h0, coreStat.txFifoLevel};
						OFS_RX_FIFO_LEVEL: s_d.rdata = {2'h0, coreStat.rxFifoLevel};
						OFS_BANK_SELECT: s_d.rdata = BANK_SET2;
						default: s_d.rdata = 8'h00;
					endcase
				end
				SET_THREE:
				begin
					case (busReq.addr)
						OFS_VERSION_ID: s_d.rdata = VERSION_ID;
						OFS_MIRROR_PORT: s_d.rdata = coreStat.portControl;
						OFS_MIRROR_FIFO: s_d.rdata = coreStat.fifoControl;
						OFS_BANK_SELECT: s_d.rdata = BANK_SET3;
						default: s_d.rdata = 8'h00;
					endcase
				end
				SET_FOUR:
				begin
					case (busReq.addr)
						OFS_TIMER_LOW: s_d.rdata = timerView[7:0];
						OFS_TIMER_HIGH: s_d.rdata = {4'h0, timerView[TIMER_W-1:8]};
						OFS_MODE_SELECT: s_d.rdata = s_q.modeSel;
						OFS_BANK_SELECT: s_d.rdata = BANK_SET4;
						OFS_TX_LEN_LOW: s_d.rdata = s_q.txRemain[7:0];
						OFS_TX_LEN_HIGH: s_d.rdata = {3'h0, s_q.txRemain[FRAME_W-1:8]};
						OFS_RX_LEN_LOW: s_d.rdata = s_q.rxCount[7:0];
						OFS_RX_LEN_HIGH: s_d.rdata = {3'h0, s_q.rxCount[FRAME_W-1:8]};
						default: s_d.rdata = 8'h00;
					endcase
				end
				SET_FIVE:
				begin
					case (busReq.addr)
						OFS_BANK_SELECT: s_d.rdata = BANK_SET5;
						OFS_IR_CONFIG: s_d.rdata = s_q.irConfig;
						default: s_d.rdata = 8'h00;
					endcase
				end
				default:
				begin
					// Sets held elsewhere in the port read zero here
					s_d.rdata = 8'h00;
				end
			endcase
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.bankSel <= BANK_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs, all straight from the state register
	assign rdata = s_q.rdata;
	assign timerExpired = s_q.timerFlag;
	assign irMode = s_q.modeSel[MODE_SEL_LO+1:MODE_SEL_LO];
	assign autoPacketMode = s_q.irConfig[CFG_AUTO_PACKET];
	assign txFrameEnd = s_q.txFrameEnd;
	assign rxStore = s_q.rxStore;
	assign maxLengthExceeded = s_q.maxLenFlag;

endmodule

/* File: verification/airf_regs_props.sv */
`timescale 1ns/100ps
module airf_regs_props
	import airf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Inputs
	input wire airf_bus_req_t busReq,
	input wire airf_core_stat_t coreStat,
	input wire airf_link_ev_t linkEv,
	input wire logic timerFlagClear,
	// Outputs
	input wire logic [7:0] rdata,
	input wire logic timerExpired,
	input wire logic [1:0] irMode,
	input wire logic autoPacketMode,
	input wire logic txFrameEnd,
	input wire logic rxStore,
	input wire logic maxLengthExceeded
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_RD_IDLE: assert property (!busReq.rd |=> rdata == 8'h00)
		else $error("read data without read");
	AST_STORE_CAUSE: assert property (rxStore |-> $past(linkEv.rxByteValid))
		else $error("store without byte");
	AST_STORE_NOFLAG: assert property (rxStore |-> !maxLengthExceeded)
		else $error("store while exceeded");
	AST_MAXLEN_BLOCK: assert property (maxLengthExceeded && !linkEv.rxFrameStart |=> !rxStore)
		else $error("store after overlong frame");
	AST_START_CLEAR: assert property (linkEv.rxFrameStart |=> !maxLengthExceeded)
		else $error("flag kept after frame start");
	AST_TX_GATE: assert property (txFrameEnd |-> $past(linkEv.txByteSent && autoPacketMode))
		else $error("frame end without byte");
	AST_TIMER_STICKY: assert property (timerExpired && !timerFlagClear |=> timerExpired)
		else $error("timer flag lost");
	AST_MODE_HOLD: assert property (!busReq.wr |=> $stable(irMode))
		else $error("mode changed without write");
	AST_APM_HOLD: assert property (!busReq.wr |=> $stable(autoPacketMode))
		else $error("packet mode changed without write");
endmodule
bind airf_regs airf_regs_props u_airf_regs_props (.clk, .reset_n, .busReq, .coreStat, .linkEv,
	.timerFlagClear, .rdata, .timerExpired, .irMode, .autoPacketMode, .txFrameEnd, .rxStore,
	.maxLengthExceeded);

/* File: verification/airf_link_model.sv */
`timescale 1ns/100ps
module airf_link_model
	import airf_pkg::*;
(
	// Clock
	input wire logic clk,
	// Link side
	output airf_link_ev_t linkEv,
	output airf_core_stat_t coreStat
);
	initial linkEv = '0;
	initial coreStat = '0;
	// ==========================================
	// Events last one cycle, so a stuck pulse cannot hide a miscount
	task automatic ev(input logic t, input logic r, input logic s);
		@(posedge clk);
		linkEv <= '{t, r, s};
		@(posedge clk);
		linkEv <= '0;
	endtask
	// Core levels, six-bit depths only
	task automatic lv(input logic [5:0] tl, input logic [5:0] rl, input logic [7:0] pc,
		input logic [7:0] fc);
		@(posedge clk);
		coreStat <= '{tl, rl, pc, fc};
	endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb
	import airf_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	airf_bus_req_t busReq = '0;
	logic timerFlagClear = 1'b0;
	logic [7:0] rdata;
	airf_core_stat_t coreStat;
	airf_link_ev_t linkEv;
	logic timerExpired, autoPacketMode, txFrameEnd, rxStore, maxLengthExceeded;
	logic [1:0] irMode;
	int errTotal = 0;
	int checks = 0;
	always #4 clk = ~clk;
	// Short tick keeps timer runs brief
	airf_regs #(.TICK_CYCLES(4), .VERSION_ID(8'h5A)) u_airf_regs (.clk, .reset_n, .busReq,
		.rdata, .coreStat, .linkEv, .timerFlagClear, .timerExpired, .irMode, .autoPacketMode,
		.txFrameEnd, .rxStore, .maxLengthExceeded);
	airf_link_model u_airf_link_model (.clk, .linkEv, .coreStat);
	// ==========================================
	// Bus and compare helpers
	task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
		checks++;
		if (g !== e)
		begin
			errTotal++;
			$display("wrong value %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		busReq <= '0;
		#1;
	endtask
	task automatic rd(input string n, input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		busReq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		busReq <= '0;
		#1 chk(n, e, rdata);
	endtask
	task automatic link(input logic t, input logic r, input logic s);
		u_airf_link_model.ev(t, r, s);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_sets;
		u_airf_link_model.lv(6'h3F, 6'h15, 8'hA5, 8'h3C);
		rd("reset bank", OFS_BANK_SELECT, BANK_RESET);
		wr(OFS_BANK_SELECT, BANK_SET3);
		wr(OFS_VERSION_ID, 8'hFF);
		rd("version", OFS_VERSION_ID, 8'h5A);
		rd("port mirror", OFS_MIRROR_PORT, 8'hA5);
		rd("fifo mirror", OFS_MIRROR_FIFO, 8'h3C);
		rd("set3 select", OFS_BANK_SELECT, BANK_SET3);
		wr(OFS_BANK_SELECT, BANK_SET2);
		wr(OFS_TX_FIFO_LEVEL, 8'h00);
		rd("tx level", OFS_TX_FIFO_LEVEL, 8'h3F);
		rd("rx level", OFS_RX_FIFO_LEVEL, 8'h15);
		$display("set test done");
	endtask
	task automatic t_timer;
		int n;
		wr(OFS_BANK_SELECT, BANK_SET4);
		rd("set4 select", OFS_BANK_SELECT, BANK_SET4);
		wr(OFS_TIMER_LOW, 8'h02);
		wr(OFS_TIMER_HIGH, 8'hF0);
		rd("timer high", OFS_TIMER_HIGH, 8'h00);
		wr(OFS_MODE_SELECT, 8'h01);
		n = 0;
		while (timerExpired !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("expiry time", 1, n > 9 && n < 20);
		chk("expired", 1, timerExpired);
		wr(OFS_MODE_SELECT, 8'h02);
		@(posedge clk);
		timerFlagClear <= 1'b1;
		@(posedge clk);
		timerFlagClear <= 1'b0;
		repeat (20) @(posedge clk);
		#1 chk("stopped", 0, timerExpired);
		rd("reload low", OFS_TIMER_LOW, 8'h02);
		// Software order only; reserved bits 7:4 are written as ones and read back as zero
		for (int m = 0; m < 4; m++)
		begin
			wr(OFS_MODE_SELECT, {4'hF, m[1:0], 2'b00});
			chk("ir mode", m[1:0], irMode);
			rd("mode read", OFS_MODE_SELECT, {4'h0, m[1:0], 2'b00});
		end
		$display("timer test done");
	endtask
	task automatic t_tx;
		wr(OFS_BANK_SELECT, BANK_SET5);
		wr(OFS_IR_CONFIG, 8'h20);
		chk("auto packet", 1, autoPacketMode);
		wr(OFS_BANK_SELECT, BANK_SET4);
		wr(OFS_TX_LEN_HIGH, 8'h00);
		wr(OFS_TX_LEN_LOW, 8'h02);
		link(1'b1, 1'b0, 1'b0);
		chk("early end", 0, txFrameEnd);
		rd("tx remain", OFS_TX_LEN_LOW, 8'h01);
		link(1'b1, 1'b0, 1'b0);
		chk("frame end", 1, txFrameEnd);
		rd("tx reload", OFS_TX_LEN_LOW, 8'h02);
		wr(OFS_TX_LEN_HIGH, 8'hFF);
		rd("tx high", OFS_TX_LEN_HIGH, 8'h1F);
		$display("transmit test done");
	endtask
	task automatic t_rx;
		wr(OFS_RX_LEN_LOW, 8'h01);
		wr(OFS_RX_LEN_HIGH, 8'h00);
		link(1'b0, 1'b1, 1'b1);
		chk("store", 1, rxStore);
		rd("rx count", OFS_RX_LEN_LOW, 8'h01);
		link(1'b0, 1'b1, 1'b0);
		chk("store over", 0, rxStore);
		chk("exceeded", 1, maxLengthExceeded);
		link(1'b0, 1'b0, 1'b1);
		chk("exceeded clear", 0, maxLengthExceeded);
		rd("rx restart", OFS_RX_LEN_LOW, 8'h00);
		$display("receive test done");
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_sets();
		t_timer();
		t_tx();
		t_rx();
		wrap_up();
	end
	initial
	begin
		#20000;
		errTotal++;
		wrap_up();
	end
endmodule
